// ===== design/scr_pkg.sv
// Package with register map, field positions, reset values and types of the global control bank.
// Functional notes
// - With the buffer reserve bit at 1 (reset value) and multiple queues on, each port gets 48 buffers held for the three upper queues.
// - With the buffer reserve bit at 0, nothing is held for high priority and each port gets 48 buffers shared by all four queues.
// - Bit 7 of register 0x05 (reset 0) turns 802.1Q VLAN mode on when set and off when clear.
// - Bit 6 of register 0x05 sends every IGMP packet to the switch MII port when set; clear means no IGMP snooping.
// - Bit 5 of register 0x05 enables MLD snooping and bit 4 enables its option, both reset to 0.
// - With weighted fair queuing off (bit 3, reset 0) the egress picks the highest waiting queue every time.
// - With weighted fair queuing on and all four queues waiting, bandwidth splits 8:4:2:1 from top to lowest queue.
// - Under weighted fair queuing each empty queue gives one extra weight to the highest waiting queue and gets no share.
// - With the sniff select bit at 1 a packet is mirrored only when source and destination ports both match.
// - With the sniff select bit at 0 (reset) a packet is mirrored when either source or destination matches.
// - Bit 7 of register 0x06 (reset 0) selects low-latency repeater mode when set, normal switching when clear.
// - Bit 6 of register 0x06 selects half duplex on the switch MII when set; its reset value is taken from the duplex strap.
package scr_pkg;

   localparam logic [7:0] SCR_ADDR_CTRL2 = 8'h04;
   localparam logic [7:0] SCR_ADDR_FEATURES = 8'h05;
   localparam logic [7:0] SCR_ADDR_MODES = 8'h06;

   localparam int SCR_BIT_PBUF_RESERVE = 0;
   localparam int SCR_BIT_VLAN_EN = 7;
   localparam int SCR_BIT_IGMP_SNOOP = 6;
   localparam int SCR_BIT_MLD_EN = 5;
   localparam int SCR_BIT_MLD_OPT = 4;
   localparam int SCR_BIT_WFQ_EN = 3;
   localparam int SCR_BIT_SNIFF_AND = 0;
   localparam int SCR_BIT_REPEATER = 7;
   localparam int SCR_BIT_MII_HDX = 6;

   localparam logic SCR_RST_PBUF_RESERVE = 1'b1;
   localparam logic [7:0] SCR_RST_FEATURES = 8'h00;
   localparam logic SCR_RST_REPEATER = 1'b0;

   localparam logic [5:0] SCR_BUFS_PER_PORT = 6'h30;
   localparam logic [5:0] SCR_BUFS_NONE = 6'h00;

   localparam logic [3:0] SCR_WEIGHT_TOP = 4'h8;
   localparam logic [3:0] SCR_WEIGHT_HIGH = 4'h4;
   localparam logic [3:0] SCR_WEIGHT_LOW = 4'h2;
   localparam logic [3:0] SCR_WEIGHT_LOWEST = 4'h1;
   localparam logic [3:0] SCR_TOP_RUN_LIMIT = 4'h9;

   typedef struct packed {
      logic [3:0][3:0] credit;
      logic [3:0] grant;
      logic grant_vld;
   } scr_sched_state_t;

   typedef struct packed {
      logic pbuf_reserve;
      logic [7:0] features;
      logic repeater;
      logic mii_hdx;
      logic [7:0] rdata;
      logic mirror;
      logic igmp_fwd;
      logic mld_fwd;
      logic [5:0] high_bufs;
      logic [5:0] shared_bufs;
   } scr_regs_state_t;

   // Returns the highest set bit of a queue mask as a one-hot vector.
   function automatic logic [3:0] scr_highest(input logic [3:0] mask);
      logic [3:0] pick;
      pick = 4'h0;
      if (mask[3]) begin
         pick = 4'h8;
      end else if (mask[2]) begin
         pick = 4'h4;
      end else if (mask[1]) begin
         pick = 4'h2;
      end else if (mask[0]) begin
         pick = 4'h1;
      end
      return pick;
   endfunction

   function automatic logic [3:0] scr_weight(input int idx);
      logic [3:0] w;
      w = SCR_WEIGHT_LOWEST;
      case (idx)
         3: w = SCR_WEIGHT_TOP;
         2: w = SCR_WEIGHT_HIGH;
         1: w = SCR_WEIGHT_LOW;
         default: w = SCR_WEIGHT_LOWEST;
      endcase
      return w;
   endfunction

endpackage

// ===== design/scr_sched_if.sv
// Interface between the register bank and the egress scheduler.
`timescale 1ns/1ps
`default_nettype none
interface scr_sched_if;
   logic wfq_en;
   logic [3:0] nonempty;
   logic slot;
   logic [3:0] grant;
   logic grant_vld;

   modport ctrl (
      output wfq_en,
      output nonempty,
      output slot,
      input grant,
      input grant_vld
   );

   modport sched (
      input wfq_en,
      input nonempty,
      input slot,
      output grant,
      output grant_vld
   );
endinterface
`default_nettype wire

// ===== design/scr_egress_sched.sv
// Egress queue picker: strict priority or weighted fair queuing.
`timescale 1ns/1ps
`default_nettype none
module scr_egress_sched
   import scr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   scr_sched_if.sched sif
);

   scr_sched_state_t s_q;
   scr_sched_state_t s_d;

   always_comb begin
      logic [3:0] eligible;
      logic [3:0] top;
      logic [3:0] pick;
      logic [3:0] bonus;
      eligible = 4'h0;
      top = scr_highest(sif.nonempty);
      pick = 4'h0;
      bonus = 4'h0;
      s_d = s_q;
      s_d.grant_vld = 1'b0;
      if (sif.slot) begin
         if (!sif.wfq_en) begin
            pick = top;
         end else begin
            for (int i = 0; i < 4; i++) begin
               eligible[i] = sif.nonempty[i] && (s_q.credit[i] != 4'h0);
            end
            if (eligible == 4'h0) begin
               // A new round: each empty queue lends one unit to the top waiting queue.
               for (int i = 0; i < 4; i++) begin
                  bonus = bonus + {3'h0, !sif.nonempty[i]};
               end
               for (int i = 0; i < 4; i++) begin
                  s_d.credit[i] = !sif.nonempty[i] ? 4'h0 :
                     scr_weight(i) + (top[i] ? bonus : 4'h0);
               end
               eligible = sif.nonempty;
            end
            pick = scr_highest(eligible);
            for (int i = 0; i < 4; i++) begin
               if (pick[i]) begin
                  s_d.credit[i] = s_d.credit[i] - 4'h1;
               end
            end
         end
         s_d.grant = pick;
         s_d.grant_vld = (pick != 4'h0);
      end
      if (sys_rst_i) begin
         s_d = '0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      s_q <= s_d;
   end

   assign sif.grant = s_q.grant;
   assign sif.grant_vld = s_q.grant_vld;

endmodule
`default_nettype wire

// ===== design/scr_global_ctrl.sv
// Global control register bank of the switch with its forwarding, buffer and queuing hooks.
`timescale 1ns/1ps
`default_nettype none
module scr_global_ctrl
   import scr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic mii_duplex_strap_pin_i,
   input wire logic multi_queue_i,
   input wire logic pkt_valid_i,
   input wire logic src_match_i,
   input wire logic dst_match_i,
   input wire logic pkt_is_igmp_i,
   input wire logic pkt_is_mld_i,
   input wire logic [3:0] queue_nonempty_i,
   input wire logic tx_slot_i,
   output logic [3:0] queue_grant_o,
   output logic queue_grant_vld_o,
   output logic prio_buf_reserve_o,
   output logic [5:0] high_prio_bufs_o,
   output logic [5:0] shared_bufs_o,
   output logic vlan_enable_o,
   output logic igmp_snoop_o,
   output logic mld_snoop_o,
   output logic mld_option_o,
   output logic wfq_enable_o,
   output logic sniff_and_o,
   output logic repeater_mode_o,
   output logic mii_half_duplex_o,
   output logic mirror_o,
   output logic igmp_to_mii_o,
   output logic mld_to_mii_o
);

   scr_regs_state_t r_q;
   scr_regs_state_t r_d;
   scr_sched_if sif ();

   assign sif.wfq_en = r_q.features[SCR_BIT_WFQ_EN];
   assign sif.nonempty = queue_nonempty_i;
   assign sif.slot = tx_slot_i;

   scr_egress_sched u_sched (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .sif(sif)
   );

   always_comb begin
      r_d = r_q;
      // Register writes; fields hold until rewritten.
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            SCR_ADDR_CTRL2: r_d.pbuf_reserve = reg_wdata_i[SCR_BIT_PBUF_RESERVE];
            SCR_ADDR_FEATURES: r_d.features = reg_wdata_i;
            SCR_ADDR_MODES: begin
               r_d.repeater = reg_wdata_i[SCR_BIT_REPEATER];
               r_d.mii_hdx = reg_wdata_i[SCR_BIT_MII_HDX];
            end
            default: r_d.features = r_q.features;
         endcase
      end
      // Reads of unmapped addresses and unowned bits of 0x04 and 0x06 return zero; 0x05 reads back its whole written byte.
      if (reg_rd_i) begin
         r_d.rdata = 8'h00;
         unique case (reg_addr_i)
            SCR_ADDR_CTRL2: r_d.rdata[SCR_BIT_PBUF_RESERVE] = r_q.pbuf_reserve;
            SCR_ADDR_FEATURES: r_d.rdata = r_q.features;
            SCR_ADDR_MODES: begin
               r_d.rdata[SCR_BIT_REPEATER] = r_q.repeater;
               r_d.rdata[SCR_BIT_MII_HDX] = r_q.mii_hdx;
            end
            default: r_d.rdata = 8'h00;
         endcase
      end
      // Reservation applies only while multiple queues run.
      if (r_q.pbuf_reserve && multi_queue_i) begin
         r_d.high_bufs = SCR_BUFS_PER_PORT;
         r_d.shared_bufs = SCR_BUFS_NONE;
      end else begin
         r_d.high_bufs = SCR_BUFS_NONE;
         r_d.shared_bufs = SCR_BUFS_PER_PORT;
      end
      if (r_q.features[SCR_BIT_SNIFF_AND]) begin
         r_d.mirror = pkt_valid_i && src_match_i && dst_match_i;
      end else begin
         r_d.mirror = pkt_valid_i && (src_match_i || dst_match_i);
      end
      r_d.igmp_fwd = pkt_valid_i && pkt_is_igmp_i && r_q.features[SCR_BIT_IGMP_SNOOP];
      r_d.mld_fwd = pkt_valid_i && pkt_is_mld_i && r_q.features[SCR_BIT_MLD_EN];
      if (sys_rst_i) begin
         r_d = '0;
         r_d.pbuf_reserve = SCR_RST_PBUF_RESERVE;
         r_d.features = SCR_RST_FEATURES;
         r_d.repeater = SCR_RST_REPEATER;
         r_d.mii_hdx = mii_duplex_strap_pin_i;
         r_d.shared_bufs = SCR_BUFS_PER_PORT;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      r_q <= r_d;
   end

   assign reg_rdata_o = r_q.rdata;
   assign prio_buf_reserve_o = r_q.pbuf_reserve;
   assign high_prio_bufs_o = r_q.high_bufs;
   assign shared_bufs_o = r_q.shared_bufs;
   assign vlan_enable_o = r_q.features[SCR_BIT_VLAN_EN];
   assign igmp_snoop_o = r_q.features[SCR_BIT_IGMP_SNOOP];
   assign mld_snoop_o = r_q.features[SCR_BIT_MLD_EN];
   assign mld_option_o = r_q.features[SCR_BIT_MLD_OPT];
   assign wfq_enable_o = r_q.features[SCR_BIT_WFQ_EN];
   assign sniff_and_o = r_q.features[SCR_BIT_SNIFF_AND];
   assign repeater_mode_o = r_q.repeater;
   assign mii_half_duplex_o = r_q.mii_hdx;
   assign mirror_o = r_q.mirror;
   assign igmp_to_mii_o = r_q.igmp_fwd;
   assign mld_to_mii_o = r_q.mld_fwd;
   assign queue_grant_o = sif.grant;
   assign queue_grant_vld_o = sif.grant_vld;

   // Counts top-queue grants since the lowest queue was last served with all queues busy.
   logic [3:0] top_run_q;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !wfq_enable_o || queue_nonempty_i != 4'hf) begin
         top_run_q <= 4'h0;
      end else if (queue_grant_vld_o && queue_grant_o[0]) begin
         top_run_q <= 4'h0;
      end else if (queue_grant_vld_o && queue_grant_o[3]) begin
         top_run_q <= top_run_q + 4'h1;
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_buf_reserved: assert property (
      prio_buf_reserve_o && multi_queue_i |=> high_prio_bufs_o == SCR_BUFS_PER_PORT
         && shared_bufs_o == SCR_BUFS_NONE)
      else $error("reserved buffers not given to upper queues");

   chk_buf_shared: assert property (
      !prio_buf_reserve_o |=> shared_bufs_o == SCR_BUFS_PER_PORT
         && high_prio_bufs_o == SCR_BUFS_NONE)
      else $error("shared buffers missing with reserve off");

   chk_vlan_write: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_FEATURES
         |=> vlan_enable_o == $past(reg_wdata_i[SCR_BIT_VLAN_EN]))
      else $error("vlan enable does not follow write");

   chk_igmp_forward: assert property (
      pkt_valid_i && pkt_is_igmp_i |=> igmp_to_mii_o == $past(igmp_snoop_o))
      else $error("igmp forward does not follow snoop bit");

   chk_mld_bits: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_FEATURES
         |=> {mld_snoop_o, mld_option_o} == $past(reg_wdata_i[5:4]))
      else $error("mld bits do not follow write");

   chk_strict_prio: assert property (
      tx_slot_i && !wfq_enable_o |=> queue_grant_o == scr_highest($past(queue_nonempty_i)))
      else $error("strict priority grant not highest queue");

   chk_wfq_ratio: assert property (
      top_run_q <= SCR_TOP_RUN_LIMIT)
      else $error("top queue exceeds its weighted share");

   chk_wfq_empty_share: assert property (
      tx_slot_i && wfq_enable_o |=> (queue_grant_o & ~$past(queue_nonempty_i)) == 4'h0)
      else $error("empty queue received a grant");

   chk_sniff_mode: assert property (
      pkt_valid_i && sniff_and_o && !(src_match_i && dst_match_i) |=> !mirror_o)
      else $error("and-mode mirrored a half match");

   chk_sniff_either: assert property (
      pkt_valid_i && !sniff_and_o && (src_match_i || dst_match_i) |=> mirror_o)
      else $error("or-mode missed a match");

   chk_repeater_write: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_MODES
         |=> repeater_mode_o == $past(reg_wdata_i[SCR_BIT_REPEATER]))
      else $error("repeater bit does not follow write");

   chk_duplex_strap: assert property (@(posedge sys_clk_i) disable iff (1'b0)
      $fell(sys_rst_i) |-> mii_half_duplex_o == $past(mii_duplex_strap_pin_i))
      else $error("duplex bit not loaded from strap");

   chk_field_hold: assert property (
      !reg_wr_i |=> $stable(r_q.features) && $stable(mii_half_duplex_o))
      else $error("field changed without a write");

   chk_pbuf_write: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_CTRL2
         |=> prio_buf_reserve_o == $past(reg_wdata_i[SCR_BIT_PBUF_RESERVE]))
      else $error("reserve bit does not follow write");

   chk_pbuf_hold: assert property (
      !(reg_wr_i && reg_addr_i == SCR_ADDR_CTRL2)
         |=> $stable(prio_buf_reserve_o))
      else $error("reserve bit changed without its write");

   chk_buf_multi_off: assert property (
      !multi_queue_i
         |=> shared_bufs_o == SCR_BUFS_PER_PORT && high_prio_bufs_o == SCR_BUFS_NONE)
      else $error("buffers reserved with single queue");

   chk_igmp_write: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_FEATURES
         |=> igmp_snoop_o == $past(reg_wdata_i[SCR_BIT_IGMP_SNOOP]))
      else $error("igmp snoop bit does not follow write");

   chk_wfq_write: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_FEATURES
         |=> wfq_enable_o == $past(reg_wdata_i[SCR_BIT_WFQ_EN]))
      else $error("weighted queue bit does not follow write");

   chk_sniff_write: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_FEATURES
         |=> sniff_and_o == $past(reg_wdata_i[SCR_BIT_SNIFF_AND]))
      else $error("sniff select bit does not follow write");

   chk_hdx_write: assert property (
      reg_wr_i && reg_addr_i == SCR_ADDR_MODES
         |=> mii_half_duplex_o == $past(reg_wdata_i[SCR_BIT_MII_HDX]))
      else $error("half duplex bit does not follow write");

   chk_features_hold: assert property (
      !(reg_wr_i && reg_addr_i == SCR_ADDR_FEATURES)
         |=> $stable(r_q.features))
      else $error("feature byte changed without its write");

   chk_modes_hold: assert property (
      !(reg_wr_i && reg_addr_i == SCR_ADDR_MODES)
         |=> $stable(repeater_mode_o) && $stable(mii_half_duplex_o))
      else $error("mode bits changed without their write");

   chk_rdata_ctrl2: assert property (
      reg_rd_i && reg_addr_i == SCR_ADDR_CTRL2
         |=> reg_rdata_o == {7'h00, $past(prio_buf_reserve_o)})
      else $error("reserve register read back wrong");

   chk_rdata_features: assert property (
      reg_rd_i && reg_addr_i == SCR_ADDR_FEATURES
         |=> reg_rdata_o == $past(r_q.features))
      else $error("feature register read back wrong");

   chk_rdata_modes: assert property (
      reg_rd_i && reg_addr_i == SCR_ADDR_MODES
         |=> reg_rdata_o[SCR_BIT_REPEATER] == $past(repeater_mode_o)
         && reg_rdata_o[SCR_BIT_MII_HDX] == $past(mii_half_duplex_o)
         && reg_rdata_o[5:0] == 6'h00)
      else $error("mode register read back wrong");

   chk_rdata_unmapped: assert property (
      reg_rd_i && reg_addr_i != SCR_ADDR_CTRL2 && reg_addr_i != SCR_ADDR_FEATURES
         && reg_addr_i != SCR_ADDR_MODES |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");

   chk_rdata_hold: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data changed without a read");

   chk_mld_forward: assert property (
      pkt_valid_i && pkt_is_mld_i |=> mld_to_mii_o == $past(mld_snoop_o))
      else $error("mld forward does not follow snoop bit");

   chk_pulse_idle: assert property (
      !pkt_valid_i |=> !mirror_o && !igmp_to_mii_o && !mld_to_mii_o)
      else $error("packet decision without a packet");

   chk_sniff_and_hit: assert property (
      pkt_valid_i && sniff_and_o && src_match_i && dst_match_i |=> mirror_o)
      else $error("and-mode missed a full match");

   chk_sniff_or_miss: assert property (
      pkt_valid_i && !sniff_and_o && !src_match_i && !dst_match_i |=> !mirror_o)
      else $error("or-mode mirrored without a match");

   chk_grant_onehot: assert property (
      queue_grant_vld_o |-> $onehot(queue_grant_o))
      else $error("grant is not one queue");

   chk_grant_none: assert property (
      tx_slot_i && queue_nonempty_i == 4'h0 |=> !queue_grant_vld_o)
      else $error("grant given with all queues empty");

   chk_no_slot: assert property (
      !tx_slot_i |=> !queue_grant_vld_o && $stable(queue_grant_o))
      else $error("grant changed without a slot");

endmodule
`default_nettype wire

// ===== bench/switch_global_control_regs_tb.sv
// Self-checking testbench of the global control register bank.
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_regs_tb;
   import scr_pkg::*;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic mii_duplex_strap_pin_i = 1'b0;
   logic multi_queue_i = 1'b0;
   logic pkt_valid_i = 1'b0;
   logic src_match_i = 1'b0;
   logic dst_match_i = 1'b0;
   logic pkt_is_igmp_i = 1'b0;
   logic pkt_is_mld_i = 1'b0;
   logic [3:0] queue_nonempty_i = 4'h0;
   logic tx_slot_i = 1'b0;
   logic [3:0] queue_grant_o;
   logic queue_grant_vld_o, prio_buf_reserve_o, vlan_enable_o, igmp_snoop_o, mld_snoop_o;
   logic [5:0] high_prio_bufs_o, shared_bufs_o;
   logic mld_option_o, wfq_enable_o, sniff_and_o, repeater_mode_o, mii_half_duplex_o;
   logic mirror_o, igmp_to_mii_o, mld_to_mii_o;
   int mismatches = 0;
   int tests_run = 0;
   logic [7:0] seed = 8'h55;
   logic [7:0] d;

   scr_global_ctrl u_dut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .mii_duplex_strap_pin_i(mii_duplex_strap_pin_i),
      .multi_queue_i(multi_queue_i), .pkt_valid_i(pkt_valid_i), .src_match_i(src_match_i),
      .dst_match_i(dst_match_i), .pkt_is_igmp_i(pkt_is_igmp_i), .pkt_is_mld_i(pkt_is_mld_i),
      .queue_nonempty_i(queue_nonempty_i), .tx_slot_i(tx_slot_i),
      .queue_grant_o(queue_grant_o), .queue_grant_vld_o(queue_grant_vld_o),
      .prio_buf_reserve_o(prio_buf_reserve_o), .high_prio_bufs_o(high_prio_bufs_o),
      .shared_bufs_o(shared_bufs_o), .vlan_enable_o(vlan_enable_o),
      .igmp_snoop_o(igmp_snoop_o), .mld_snoop_o(mld_snoop_o), .mld_option_o(mld_option_o),
      .wfq_enable_o(wfq_enable_o), .sniff_and_o(sniff_and_o),
      .repeater_mode_o(repeater_mode_o), .mii_half_duplex_o(mii_half_duplex_o),
      .mirror_o(mirror_o), .igmp_to_mii_o(igmp_to_mii_o), .mld_to_mii_o(mld_to_mii_o)
   );

   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Packet decision expected from feature byte f and p = {src, dst, igmp, mld}.
   function automatic logic [7:0] exp_pkt(input logic [7:0] f, input logic [3:0] p);
      logic m;
      m = f[0] ? (p[3] & p[2]) : (p[3] | p[2]);
      return {5'h00, m, f[6] & p[1], f[5] & p[0]};
   endfunction

   function automatic logic [3:0] exp_top(input logic [3:0] ne);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 0; k < 4; k++) begin
         if (ne[k]) begin
            r = 4'h1 << k;
         end
      end
      return r;
   endfunction

   task automatic end_of_test;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step;
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic reset_dut(input logic strap);
      step();
      sys_rst_i = 1'b1;
      mii_duplex_strap_pin_i = strap;
      repeat (5) step();
      sys_rst_i = 1'b0;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      step();
      reg_wr_i = 1'b0;
      step();
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      step();
      reg_rd_i = 1'b0;
      chk(reg_rdata_o, exp);
      step();
   endtask

   task automatic pkt_chk(input logic [7:0] f, input logic [3:0] p);
      pkt_valid_i = 1'b1;
      {src_match_i, dst_match_i, pkt_is_igmp_i, pkt_is_mld_i} = p;
      step();
      pkt_valid_i = 1'b0;
      chk({5'h00, mirror_o, igmp_to_mii_o, mld_to_mii_o}, exp_pkt(f, p));
      step();
      chk({5'h00, mirror_o, igmp_to_mii_o, mld_to_mii_o}, 8'h00);
   endtask

   // Slots every cycle; exp holds the expected slot count per queue, top queue in the high byte.
   task automatic wfq_run(input logic [3:0] ne, input int n, input logic [31:0] exp);
      logic [7:0] cnt [4];
      for (int k = 0; k < 4; k++) begin
         cnt[k] = 8'h00;
      end
      queue_nonempty_i = ne;
      tx_slot_i = 1'b1;
      repeat (n) begin
         step();
         for (int k = 0; k < 4; k++) begin
            if (queue_grant_vld_o === 1'b1 && queue_grant_o[k] === 1'b1) begin
               cnt[k]++;
            end
         end
      end
      tx_slot_i = 1'b0;
      step();
      for (int k = 0; k < 4; k++) begin
         chk(cnt[k], exp[8*k +: 8]);
      end
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      mismatches++;
      end_of_test();
   end

   initial begin
      reset_dut(1'b0);
      rd_chk(SCR_ADDR_CTRL2, 8'h01);
      rd_chk(SCR_ADDR_FEATURES, 8'h00);
      rd_chk(SCR_ADDR_MODES, 8'h00);
      chk({2'b00, shared_bufs_o}, 8'h30);
      multi_queue_i = 1'b1;
      step();
      chk({2'b00, high_prio_bufs_o}, 8'h30);
      chk({2'b00, shared_bufs_o}, 8'h00);
      reg_write(SCR_ADDR_CTRL2, 8'hfe);
      chk({1'b0, prio_buf_reserve_o, high_prio_bufs_o}, 8'h00);
      chk({2'b00, shared_bufs_o}, 8'h30);
      rd_chk(SCR_ADDR_CTRL2, 8'h00);
      reg_write(SCR_ADDR_CTRL2, 8'h01);
      multi_queue_i = 1'b0;
      step();
      chk({2'b00, high_prio_bufs_o}, 8'h00);
      chk({2'b00, shared_bufs_o}, 8'h30);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         d = (i == 0) ? 8'hf9 : {seed[7:3], 2'b00, seed[0]};
         // No VLAN table sits behind this bank, so the enable bit needs no table setup first.
         reg_write(SCR_ADDR_FEATURES, d);
         chk({vlan_enable_o, igmp_snoop_o, mld_snoop_o, mld_option_o, wfq_enable_o,
              2'b00, sniff_and_o}, d);
         reg_write(8'h07, ~d);
         rd_chk(SCR_ADDR_FEATURES, d);
         rd_chk(8'h07, 8'h00);
         for (int j = 0; j < 4; j++) begin
            seed = lfsr(seed);
            pkt_chk(d, seed[3:0]);
         end
      end
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         d = (i == 0) ? 8'hff : seed;
         // Port speed and negotiation live outside this bank; only the repeater and half-duplex bits are exercised.
         reg_write(SCR_ADDR_MODES, d);
         chk({repeater_mode_o, mii_half_duplex_o, 6'h00}, d & 8'hc0);
         rd_chk(SCR_ADDR_MODES, d & 8'hc0);
      end
      reg_write(SCR_ADDR_FEATURES, 8'h00);
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         queue_nonempty_i = (i == 0) ? 4'h0 : ((i == 1) ? 4'hf : seed[3:0]);
         tx_slot_i = 1'b1;
         step();
         tx_slot_i = 1'b0;
         chk({7'h00, queue_grant_vld_o}, {7'h00, queue_nonempty_i != 4'h0});
         if (queue_nonempty_i != 4'h0) begin
            chk({4'h0, queue_grant_o}, {4'h0, exp_top(queue_nonempty_i)});
         end
         step();
      end
      // A fresh reset clears scheduler credits so the rounds below start aligned.
      reset_dut(1'b1);
      rd_chk(SCR_ADDR_MODES, 8'h40);
      rd_chk(SCR_ADDR_FEATURES, 8'h00);
      reg_write(SCR_ADDR_FEATURES, 8'h08);
      wfq_run(4'hf, 15, {8'd8, 8'd4, 8'd2, 8'd1});
      wfq_run(4'hb, 12, {8'd9, 8'd0, 8'd2, 8'd1});
      end_of_test();
   end
endmodule
`default_nettype wire
